// ### common/sc_pkg.sv
// shared constants and types of the switch configuration register block
package sc_pkg;
  // register addresses
  localparam logic [7:0] SC_REG_CONFIG = 8'h01;
  localparam logic [7:0] SC_REG_ID = 8'h02;
  localparam logic [7:0] SC_REG_FAULT = 8'h04;
  localparam logic [7:0] SC_REG_ADC1 = 8'h06;
  localparam logic [7:0] SC_REG_ADC4 = 8'h09;
  // reset values
  localparam logic [7:0] SC_CONFIG_RESET = 8'h1F;
  localparam logic [7:0] SC_ZERO = 8'h00;
  // switch_configuration field positions
  localparam int SC_MUX_HI = 7;
  localparam int SC_MUX_LO = 6;
  localparam int SC_CONT_BIT = 5;
  localparam int SC_RTV_BIT = 4;
  localparam int SC_EN_HI = 3;
  localparam int SC_EN_LO = 0;
  // adc source-select codes
  localparam logic [1:0] SC_SRC_CURRENT = 2'h0;
  localparam logic [1:0] SC_SRC_VOUT = 2'h1;
  localparam logic [1:0] SC_SRC_SUPPLY = 2'h2;
  // part_identification field layout
  localparam logic [1:0] SC_ID_TOP = 2'h0;
  // bus address: upper six bits fixed, bit 0 from the address strap
  localparam logic [6:0] SC_I2C_BASE = 7'h28;
  // timing: one adc result register loaded per conversion step
  localparam int SC_CLK_PERIOD_NS = 10;
  localparam int SC_CONV_STEP_NS = 1000;
  localparam int SC_CONV_STEP_CYC = SC_CONV_STEP_NS / SC_CLK_PERIOD_NS;
  // serial engine states
  typedef enum logic [2:0] {
    SC_I_IDLE = 3'b000,
    SC_I_RX = 3'b001,
    SC_I_RX_ACK = 3'b010,
    SC_I_TX = 3'b011,
    SC_I_TX_ACK = 3'b100
  } sc_i2c_state_e;
endpackage

// ### rtl/sc_i2c_slave.sv
// two-wire serial slave engine: address match, register pointer, byte strobes
`timescale 1ns/1ps
module sc_i2c_slave (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // bus pins, raw
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  // own 7-bit address
  input wire logic [6:0] dev_addr,
  // register side
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] acc_addr,
  output logic [7:0] cur_addr,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);
  import sc_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  logic [1:0] scl_sy, sda_sy;
  logic scl_d, sda_d;
  sc_i2c_state_e state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh;
  logic [1:0] idx, next_idx;
  logic rw, next_rw, next_oe, next_wr_stb, next_rd_stb;
  logic [7:0] next_acc_addr, next_cur_addr, next_wr_data;
  logic scl_rise, scl_fall, start_c, stop_c;

  // two-flop synchronisers; edges only look at the second stage
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_sy <= {scl_sy[0], scl_in};
      sda_sy <= {sda_sy[0], sda_in};
      scl_d <= scl_sy[1];
      sda_d <= sda_sy[1];
    end
  end

  assign scl_rise = scl_sy[1] & ~scl_d;
  assign scl_fall = ~scl_sy[1] & scl_d;
  assign start_c = scl_sy[1] & scl_d & sda_d & ~sda_sy[1];
  assign stop_c = scl_sy[1] & scl_d & ~sda_d & sda_sy[1];

  //////////////////////////////////////////////////////////////////////////
  // frame: address byte, register-address byte, then data bytes
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_sh = sh;
    next_idx = idx;
    next_rw = rw;
    next_oe = sda_oe;
    next_acc_addr = acc_addr;
    next_cur_addr = cur_addr;
    next_wr_data = wr_data;
    next_wr_stb = 1'b0;
    next_rd_stb = 1'b0;
    if (start_c) begin
      next_state = SC_I_RX;
      next_cnt = 4'h0;
      next_idx = 2'h0;
      next_oe = 1'b0;
    end else if (stop_c) begin
      next_state = SC_I_IDLE;
      next_oe = 1'b0;
    end else begin
      case (state)
        SC_I_RX: begin
          if (scl_rise) begin
            next_sh = {sh[6:0], sda_sy[1]};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == 4'h8) begin
            next_cnt = 4'h0;
            next_state = SC_I_RX_ACK;
            next_oe = 1'b1;
            if (idx != 2'h2) next_idx = idx + 2'h1;
            if (idx == 2'h0) begin
              next_rw = sh[0];
              // not our address: stay off the bus until the next start
              if (sh[7:1] != dev_addr) begin
                next_state = SC_I_IDLE;
                next_oe = 1'b0;
              end
            end else if (idx == 2'h1) begin
              next_cur_addr = sh;
            end else begin
              next_wr_data = sh;
              next_wr_stb = 1'b1;
              next_acc_addr = cur_addr;
              next_cur_addr = cur_addr + 8'h01;
            end
          end
        end
        SC_I_RX_ACK: begin
          if (scl_fall) begin
            next_oe = 1'b0;
            next_state = SC_I_RX;
            if (rw && idx == 2'h1) begin
              next_state = SC_I_TX;
              next_sh = rd_data;
              next_oe = ~rd_data[7];
              next_rd_stb = 1'b1;
              next_acc_addr = cur_addr;
              next_cur_addr = cur_addr + 8'h01;
            end
          end
        end
        SC_I_TX: begin
          if (scl_fall) begin
            if (cnt == 4'h7) begin
              next_state = SC_I_TX_ACK;
              next_oe = 1'b0;
            end else begin
              next_cnt = cnt + 4'h1;
              next_sh = {sh[6:0], 1'b0};
              next_oe = ~sh[6];
            end
          end
        end
        SC_I_TX_ACK: begin
          // cnt[0] keeps the master's acknowledge level
          if (scl_rise) begin
            next_cnt = {3'h0, sda_sy[1]};
          end else if (scl_fall) begin
            if (!cnt[0]) begin
              next_state = SC_I_TX;
              next_cnt = 4'h0;
              next_sh = rd_data;
              next_oe = ~rd_data[7];
              next_rd_stb = 1'b1;
              next_acc_addr = cur_addr;
              next_cur_addr = cur_addr + 8'h01;
            end else begin
              next_state = SC_I_IDLE;
            end
          end
        end
        default: next_state = SC_I_IDLE;
      endcase
    end
  end

  // engine registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= SC_I_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      idx <= 2'h0;
      rw <= 1'b0;
      sda_oe <= 1'b0;
      acc_addr <= 8'h00;
      cur_addr <= 8'h00;
      wr_data <= 8'h00;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      sh <= next_sh;
      idx <= next_idx;
      rw <= next_rw;
      sda_oe <= next_oe;
      acc_addr <= next_acc_addr;
      cur_addr <= next_cur_addr;
      wr_data <= next_wr_data;
      wr_stb <= next_wr_stb;
      rd_stb <= next_rd_stb;
    end
  end

  AST_WR_ADDR_STEP: assert property (@(posedge clock) disable iff (!nrst)
    wr_stb |-> cur_addr == acc_addr + 8'h01)
    else $error("pointer did not advance after a data write");
endmodule // sc_i2c_slave

// ### rtl/sc_switch_config.sv
// configuration, identification, fault view and adc result registers
`timescale 1ns/1ps
module sc_switch_config #(
  parameter logic [1:0] PART_CODE = 2'h2, // arbitrary value
  parameter logic [3:0] REVISION = 4'h0,
  parameter bit EXT_DIAG = 1'b1,
  parameter int CONV_STEP_CYC = sc_pkg::SC_CONV_STEP_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // straps and control pins
  input wire logic addr_pin,
  input wire logic en_pin,
  // per-channel raw fault conditions
  input wire logic [3:0] fault_in,
  // converter samples, same clock
  input wire logic [3:0][7:0] meas_current,
  input wire logic [3:0][7:0] meas_vout,
  input wire logic [7:0] meas_vin,
  input wire logic [7:0] meas_vdd,
  input wire logic [7:0] meas_current_limit_set_pin,
  // switch drive and open-drain fault interrupt
  output logic [3:0] channel_on,
  output logic int_out,
  output logic int_oe
);
  import sc_pkg::*;

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  //////////////////////////////////////////////////////////////////////////
  logic [5:0] pin_s1, pin_s2;
  logic en_s, a0_s;
  logic [3:0] fault_s;
  logic wr_stb, rd_stb;
  logic [7:0] acc_addr, cur_addr, wr_data, rd_data;
  logic [7:0] cfg_word, next_cfg_word;
  logic [3:0] status, next_status;
  logic [3:0][7:0] result, next_result;
  logic conv_busy, next_busy;
  logic [1:0] conv_idx, next_idx;
  logic [15:0] step, next_step;
  logic [3:0] next_channel_on;
  logic next_int_oe, conv_load, conv_start, rd_fault;
  logic [7:0] load_val;
  logic [1:0] cfg_mux;
  logic cfg_cont, cfg_rtv;

  // pins cross in through two flops; first stage feeds only the second
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_s1 <= 6'h00;
      pin_s2 <= 6'h00;
    end else begin
      pin_s1 <= {fault_in, addr_pin, en_pin};
      pin_s2 <= pin_s1;
    end
  end
  assign en_s = pin_s2[0];
  assign a0_s = pin_s2[1];
  assign fault_s = pin_s2[5:2];

  sc_i2c_slave u_bus (
    .clock(clock),
    .nrst(nrst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .dev_addr({SC_I2C_BASE[6:1], a0_s}),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .acc_addr(acc_addr),
    .cur_addr(cur_addr),
    .wr_data(wr_data),
    .rd_data(rd_data)
  );

  assign cfg_mux = cfg_word[SC_MUX_HI:SC_MUX_LO];
  assign cfg_cont = cfg_word[SC_CONT_BIT];
  assign cfg_rtv = cfg_word[SC_RTV_BIT];

  //////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses read as zero
  always_comb begin
    if (cur_addr == SC_REG_CONFIG) begin
      rd_data = cfg_word;
    end else if (cur_addr == SC_REG_ID) begin
      rd_data = {SC_ID_TOP, PART_CODE, REVISION};
    end else if (cur_addr == SC_REG_FAULT) begin
      rd_data = {4'h0, status};
    end else if (cur_addr >= SC_REG_ADC1 && cur_addr <= SC_REG_ADC4) begin
      rd_data = result[2'(cur_addr - SC_REG_ADC1)];
    end else begin
      rd_data = SC_ZERO;
    end
  end

  // source for the result register being loaded
  always_comb begin
    load_val = SC_ZERO;
    if (cfg_mux == SC_SRC_CURRENT || !EXT_DIAG) begin
      load_val = meas_current[conv_idx];
    end else if (cfg_mux == SC_SRC_VOUT) begin
      load_val = meas_vout[conv_idx];
    end else if (cfg_mux == SC_SRC_SUPPLY) begin
      // fourth result register is cleared in this mode
      if (conv_idx == 2'h0) load_val = meas_vin;
      else if (conv_idx == 2'h1) load_val = meas_vdd;
      else if (conv_idx == 2'h2) load_val = meas_current_limit_set_pin;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register writes, fault view, conversion sequencer, outputs
  assign rd_fault = rd_stb && acc_addr == SC_REG_FAULT;
  assign conv_start = cfg_cont || (rd_stb && acc_addr == SC_REG_ADC1);
  assign conv_load = conv_busy && step == 16'(CONV_STEP_CYC - 1);

  always_comb begin
    next_cfg_word = cfg_word;
    if (wr_stb && acc_addr == SC_REG_CONFIG) next_cfg_word = wr_data;
    // latched: a fault present in the clearing cycle survives the read
    if (cfg_rtv) next_status = fault_s;
    else next_status = (status & ~{4{rd_fault}}) | fault_s;
    next_int_oe = |next_status;
    next_channel_on = {4{en_s}} & cfg_word[SC_EN_HI:SC_EN_LO];
    next_busy = conv_busy;
    next_idx = conv_idx;
    next_step = step;
    next_result = result;
    if (!conv_busy) begin
      if (conv_start) begin
        next_busy = 1'b1;
        next_idx = 2'h0;
        next_step = 16'h0000;
      end
    end else if (conv_load) begin
      // results fill one after another; old values stay readable meanwhile
      next_result[conv_idx] = load_val;
      next_step = 16'h0000;
      next_idx = conv_idx + 2'h1;
      if (conv_idx == 2'h3) next_busy = 1'b0;
    end else begin
      next_step = step + 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg_word <= SC_CONFIG_RESET;
      status <= 4'h0;
      result <= '0;
      conv_busy <= 1'b0;
      conv_idx <= 2'h0;
      step <= 16'h0000;
      channel_on <= 4'h0;
      int_oe <= 1'b0;
      int_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      cfg_word <= next_cfg_word;
      status <= next_status;
      result <= next_result;
      conv_busy <= next_busy;
      conv_idx <= next_idx;
      step <= next_step;
      channel_on <= next_channel_on;
      int_oe <= next_int_oe;
      int_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  AST_SRC_CURRENT: assert property (conv_load && cfg_mux == SC_SRC_CURRENT
    |=> result[$past(conv_idx)] == $past(meas_current[conv_idx]))
    else $error("current not loaded into result register");
  AST_SRC_VOUT: assert property (conv_load && EXT_DIAG && cfg_mux == SC_SRC_VOUT
    |=> result[$past(conv_idx)] == $past(meas_vout[conv_idx]))
    else $error("output voltage not loaded into result register");
  AST_SRC_SUPPLY: assert property (conv_load && EXT_DIAG && cfg_mux == SC_SRC_SUPPLY
    |=> result[$past(conv_idx)] == ($past(conv_idx) == 2'h0 ? $past(meas_vin) :
                                    $past(conv_idx) == 2'h1 ? $past(meas_vdd) :
                                    $past(conv_idx) == 2'h2 ? $past(meas_current_limit_set_pin) : SC_ZERO))
    else $error("supply source mapping wrong");
  AST_SINGLE_START: assert property (!cfg_cont && !conv_busy && rd_stb
    && acc_addr == SC_REG_ADC1 |=> conv_busy && conv_idx == 2'h0)
    else $error("first result read did not start conversion");
  AST_SINGLE_IDLE: assert property (!cfg_cont && !conv_busy
    && !(rd_stb && acc_addr == SC_REG_ADC1) |=> !conv_busy)
    else $error("single-shot conversion started unprompted");
  AST_LATCH_HOLD: assert property (!cfg_rtv && !rd_fault
    |=> (status & $past(status)) == $past(status))
    else $error("latched fault lost without a read");
  AST_REALTIME: assert property (cfg_rtv |=> status == $past(fault_s) && int_oe == |status)
    else $error("realtime view does not follow fault");
  AST_CHANNEL_ON: assert property (1'b1
    |=> channel_on == ({4{$past(en_s)}} & $past(cfg_word[SC_EN_HI:SC_EN_LO])))
    else $error("channel drive not gated by both enables");
  AST_CONFIG_WRITE: assert property (wr_stb && acc_addr == SC_REG_CONFIG
    |=> cfg_word == $past(wr_data))
    else $error("configuration write not stored");
  // checks the byte actually loaded for shifting out, not just the mux
  AST_ID_READ: assert property (rd_stb && acc_addr == SC_REG_ID
    |-> u_bus.sh == {2'h0, PART_CODE, REVISION})
    else $error("identification read wrong");
endmodule // sc_switch_config

// ### tb/sc_i2c_host.sv
// two-wire bus master model driving the configuration block from the host side
`timescale 1ns/1ps
module sc_i2c_host (
  // clock
  input wire logic clock,
  // resolved data wire level
  input wire logic sda,
  // clock wire level and data pull-down enable
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // five clocks per phase so the slave synchronisers see every edge
  task automatic gap();
    repeat (5) @(negedge clock);
  endtask
  // start or repeated start: data falls while clock high
  task automatic start_cond();
    sda_low = 1'b0;
    gap();
    scl = 1'b1;
    gap();
    sda_low = 1'b1;
    gap();
    scl = 1'b0;
    gap();
  endtask
  // stop: data rises while clock high
  task automatic stop_cond();
    sda_low = 1'b1;
    gap();
    scl = 1'b1;
    gap();
    sda_low = 1'b0;
    gap();
  endtask
  // one bit; data only moves while the clock is low
  task automatic one_bit(input logic d, output logic q);
    sda_low = ~d;
    gap();
    scl = 1'b1;
    gap();
    q = sda;
    scl = 1'b0;
    gap();
  endtask
  // eight bits msb first, then the ninth acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                      output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      one_bit(tx[i], rx[i]);
    end
    one_bit(ack_in, ack_out);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // register write frame: address+w, register byte, one data byte, stop
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data, output logic ok);
    logic [7:0] rx;
    logic a0;
    logic a1;
    logic a2;
    start_cond();
    xfer(8'h50, 1'b1, rx, a0);
    xfer(addr, 1'b1, rx, a1);
    xfer(data, 1'b1, rx, a2);
    stop_cond();
    ok = (a0 === 1'b0) && (a1 === 1'b0) && (a2 === 1'b0);
  endtask
  // register read frame: pointer write, repeated start, one byte with nack
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    logic [7:0] rx;
    logic a;
    start_cond();
    xfer(8'h50, 1'b1, rx, a);
    xfer(addr, 1'b1, rx, a);
    start_cond();
    xfer(8'h51, 1'b1, rx, a);
    xfer(8'hFF, 1'b1, data, a);
    stop_cond();
  endtask
endmodule // sc_i2c_host

// ### tb/test_switch_config_and_id_regs.sv
// self-checking bench for the switch configuration and identification block
`timescale 1ns/1ps
module test_switch_config_and_id_regs;
  import sc_pkg::*;
  localparam int STEP = 3;
  localparam logic [1:0] PC = 2'h2; // arbitrary value
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic en_pin = 1'b0;
  logic [3:0] fault_in = 4'h0;
  logic [3:0][7:0] meas_current = '0;
  logic [3:0][7:0] meas_vout = '0;
  logic [7:0] meas_vin = 8'h00;
  logic [7:0] meas_vdd = 8'h00;
  logic [7:0] meas_current_limit_set_pin = 8'h00;
  logic scl, sda_low, sda, sda_out, sda_oe, int_out, int_oe;
  logic [3:0] channel_on;
  logic [31:0] seed = 32'h88B45BA0;
  logic [7:0] v;
  int err_count = 0;
  int num_checks = 0;
  int res[4] = '{0, 0, 0, 0};
  ////////////////////////////////////////////////////////////////////////////
  always #5 clock = ~clock;
  // open-drain data wire with pull-up
  assign sda = ~(sda_low | sda_oe);
  sc_switch_config #(.PART_CODE(PC), .CONV_STEP_CYC(STEP)) DUT (
    .clock(clock), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_pin(1'b0), .en_pin(en_pin), .fault_in(fault_in),
    .meas_current(meas_current), .meas_vout(meas_vout), .meas_vin(meas_vin),
    .meas_vdd(meas_vdd), .meas_current_limit_set_pin(meas_current_limit_set_pin), .channel_on(channel_on),
    .int_out(int_out), .int_oe(int_oe));
  sc_i2c_host host (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic rnd(output logic [7:0] r);
    repeat (8) seed = lfsr(seed);
    r = seed[7:0];
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.write_reg(a, d, ok);
    chk({7'h00, ok}, 8'h01, "write ack");
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] got;
    host.read_reg(a, got);
    chk(got, exp, "register read");
  endtask
  // reference result for one source code and one result slot
  function automatic int model_res(input int src, input int i);
    case (src)
      0: return int'(meas_current[i]);
      1: return int'(meas_vout[i]);
      2: return (i == 0) ? int'(meas_vin) : (i == 1) ? int'(meas_vdd) :
                (i == 2) ? int'(meas_current_limit_set_pin) : 0;
      default: return 0;
    endcase
  endfunction
  // fresh random measurements on all converter inputs
  task automatic new_meas();
    for (int i = 0; i < 4; i++) begin
      rnd(meas_current[i]);
      rnd(meas_vout[i]);
    end
    rnd(meas_vin);
    rnd(meas_vdd);
    rnd(meas_current_limit_set_pin);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clock);
    err_count++;
    $display("unexpected at %0t: run did not finish", $time);
    print_verdict();
  end
  initial begin
    repeat (16) @(negedge clock);
    nrst = 1'b1;
    en_pin = 1'b1;
    repeat (10) @(negedge clock);
    // reset values, identification and read-only behaviour
    chk({4'h0, channel_on}, 8'h0F, "enables after reset");
    rd(SC_REG_CONFIG, SC_CONFIG_RESET);
    rd(SC_REG_ID, {2'b00, PC, 4'h0});
    wr(SC_REG_ID, 8'hFF);
    rd(SC_REG_ID, {2'b00, PC, 4'h0});
    rd(8'h0F, SC_ZERO);
    $display("test registers done");
    // enable bits combined with the global pin
    for (int k = 0; k < 6; k++) begin
      rnd(v);
      en_pin = v[7];
      wr(SC_REG_CONFIG, {4'h1, v[3:0]});
      rd(SC_REG_CONFIG, {4'h1, v[3:0]});
      repeat (6) @(negedge clock);
      chk({4'h0, channel_on}, {4'h0, v[7] ? v[3:0] : 4'h0}, "channel drive");
    end
    $display("test enables done");
    // single-shot conversion for every source code
    for (int s = 0; s < 4; s++) begin
      new_meas();
      wr(SC_REG_CONFIG, {s[1:0], 6'h1F});
      rd(SC_REG_ADC1, res[0][7:0]);
      for (int i = 0; i < 4; i++) res[i] = model_res(s, i);
      rd(SC_REG_ADC4, res[3][7:0]);
      rd(8'h08, res[2][7:0]);
      rd(8'h07, res[1][7:0]);
      rd(SC_REG_ADC1, res[0][7:0]);
      new_meas();
      repeat (40) @(negedge clock);
      rd(8'h07, res[1][7:0]);
    end
    // continuous conversion follows new samples without a trigger
    wr(SC_REG_CONFIG, 8'h3F);
    new_meas();
    repeat (60) @(negedge clock);
    rd(8'h08, meas_current[2]);
    $display("test conversion done");
    // realtime fault view
    wr(SC_REG_CONFIG, SC_CONFIG_RESET);
    fault_in = 4'h5;
    repeat (10) @(negedge clock);
    chk({7'h00, int_oe}, 8'h01, "interrupt live");
    rd(SC_REG_FAULT, 8'h05);
    fault_in = 4'h0;
    repeat (10) @(negedge clock);
    chk({7'h00, int_oe}, 8'h00, "interrupt live off");
    rd(SC_REG_FAULT, 8'h00);
    // latched fault view holds a vanished fault until read
    wr(SC_REG_CONFIG, 8'h0F);
    fault_in = 4'hA;
    repeat (10) @(negedge clock);
    fault_in = 4'h0;
    repeat (10) @(negedge clock);
    chk({7'h00, int_oe}, 8'h01, "interrupt held");
    rd(SC_REG_FAULT, 8'h0A);
    rd(SC_REG_FAULT, 8'h00);
    chk({7'h00, int_oe}, 8'h00, "interrupt cleared");
    chk({6'h00, sda_out, int_out}, 8'h00, "open-drain pin levels");
    $display("test faults done");
    // reset in mid-run must bring the configuration back to its reset value
    en_pin = 1'b1;
    wr(SC_REG_CONFIG, 8'h1A);
    repeat (6) @(negedge clock);
    chk({4'h0, channel_on}, 8'h0A, "drive before reset");
    nrst = 1'b0;
    repeat (4) @(negedge clock);
    chk({4'h0, channel_on}, 8'h00, "drive in reset");
    nrst = 1'b1;
    repeat (10) @(negedge clock);
    chk({4'h0, channel_on}, 8'h0F, "drive after reset");
    rd(SC_REG_CONFIG, SC_CONFIG_RESET);
    $display("test reset done");
    print_verdict();
  end
endmodule // test_switch_config_and_id_regs
